/* File: common/rf_buffer_defs.svh */
// Purpose: Constants for the RF data buffer and slicer lock block
// Assumes: One 200 MHz clock; baud events arrive as one-cycle ticks
// Notes:   Offsets are byte addresses on the register port
// How it works
// - Byte mode shifts eight bits out, MSB first
// - Empty shifter reloads from buffer, buffer kept
// - Every transmit load raises the interrupt flag
// - Unwritten buffer byte is simply sent again
// - Bit mode loads buffer bit 0 per bit
// - Buffer preloaded before power-up loads at once
// - Receive shifts MSB first, full byte to buffer
// - Unread received byte is overwritten by next
// - Bit mode receive moves previous bit to bit 0
// - Slicer compares data filter with average filter
// - Lock request freezes the average filter
// - Auto lock after settling count of baud periods
// - Settling timer starts when receive mode entered
// - Lock state readable as a status bit
// - Locked level kept through power-down and transmit
// - Modem soft reset or main reset clears filter
// - Select 0 auto lock, select 1 follows request
// - Settling codes give 11, 22, 43, 86 bauds
`ifndef RF_BUFFER_DEFS_SVH
`define RF_BUFFER_DEFS_SVH

`define ADDR_RF_DATA_BUFFER      8'h00
`define ADDR_RF_CONTROL          8'h04
`define ADDR_RF_MAIN_CONTROL     8'h08
`define ADDR_DEMOD_CONTROL_ONE   8'h0c
`define ADDR_DEMOD_CONTROL_TWO   8'h10
`define ADDR_RF_STATUS           8'h14

`define RF_CONTROL_BYTEMODE_BIT       0
`define MAIN_TRANSMIT_POWER_DOWN_BIT           0
`define MAIN_RECEIVE_POWER_DOWN_BIT           1
`define MAIN_MANCHESTER_BIT      2
`define MOD1_MODEM_RUN_BIT       0
`define MOD1_PEAK_EN_BIT         1
`define MOD1_SETTLE_LSB          2
`define MOD1_LOCK_STATE_BIT      4
`define MOD1_LOCK_SELECT_BIT     5
`define MOD1_LOCK_REQUEST_BIT    6
`define STATUS_IRQ_BIT           0

`define RESET_RF_CONTROL         8'h06
`define RESET_RF_MAIN_CONTROL    8'h03
`define RESET_DEMOD_ONE          8'h2c
`define RESET_DEMOD_TWO          8'h16

`define SETTLE_CODE0             7'h0b
`define SETTLE_CODE1             7'h16
`define SETTLE_CODE2             7'h2b
`define SETTLE_CODE3             7'h56

`endif

/* File: common/rf_buffer_pkg.sv */
// Purpose: Shared types for the RF data buffer block
// Assumes: Nothing beyond the defs header
// Notes:   Types only; numbers live in the defs header
package rf_buffer_pkg;

    typedef enum logic [1:0] {
        lock_free,
        lock_settling,
        lock_held
    } lock_state_t;

endpackage : rf_buffer_pkg

/* File: rtl/slicer_lock.sv */
// Purpose: Averaging filter lock control and data slicer
// Assumes: Filter samples and baud tick synchronous to clock
// Notes:   Average is a leaky integrator; frozen while locked
`include "rf_buffer_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module slicer_lock
    import rf_buffer_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             soft_reset,
    input  wire logic             baud_tick,
    input  wire logic             sample_valid,
    input  wire logic [WIDTH-1:0] data_filter,
    input  wire logic             receive_on,
    input  wire logic             lock_select,
    input  wire logic             lock_request,
    input  wire logic [1:0]       settling,
    output logic                  sliced_bit,
    output logic                  locked
);

    function automatic logic [6:0] settle_count(input logic [1:0] code);
        unique case (code)
            2'h0: settle_count = `SETTLE_CODE0;
            2'h1: settle_count = `SETTLE_CODE1;
            2'h2: settle_count = `SETTLE_CODE2;
            2'h3: settle_count = `SETTLE_CODE3;
        endcase
    endfunction : settle_count

    lock_state_t      state;
    lock_state_t      next_state;
    logic [6:0]       timer;
    logic [6:0]       next_timer;
    logic [WIDTH+3:0] acc;
    logic [WIDTH+3:0] next_acc;
    logic             receive_was;
    logic             next_sliced_bit;
    logic [WIDTH-1:0] average;

    assign average = acc[WIDTH+3:4];

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_acc   = acc;
        if (lock_select) begin
            next_state = lock_request ? lock_held : lock_free;
            next_timer = 7'h00;
        end else begin
            if (receive_on && !receive_was) begin
                next_state = lock_settling;
                next_timer = 7'h00;
            end else if (state == lock_settling && receive_on
                         && baud_tick) begin
                next_timer = timer + 7'h01;
                if (timer + 7'h01 >= settle_count(settling))
                    next_state = lock_held;
            end
        end
        // Held level survives power-down and transmit
        if (state != lock_held && receive_on && sample_valid)
            next_acc = acc - {4'h0, average} + {4'h0, data_filter};
        next_sliced_bit = sliced_bit;
        if (sample_valid)
            next_sliced_bit = (data_filter > average);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state       <= lock_free;
            timer       <= 7'h00;
            acc         <= '0;
            receive_was <= 1'b0;
            sliced_bit  <= 1'b0;
            locked      <= 1'b0;
        end else if (soft_reset) begin
            state       <= lock_free;
            timer       <= 7'h00;
            acc         <= '0;
            receive_was <= 1'b0;
            sliced_bit  <= 1'b0;
            locked      <= 1'b0;
        end else begin
            state       <= next_state;
            timer       <= next_timer;
            acc         <= next_acc;
            receive_was <= receive_on;
            sliced_bit  <= next_sliced_bit;
            locked      <= (next_state == lock_held);
        end
    end

endmodule : slicer_lock
`default_nettype wire

/* File: rtl/rx_deserializer.sv */
// Purpose: Receive shift register feeding the data buffer
// Assumes: One bit per bit_tick while receiving
// Notes:   Byte overwrites buffer with no check of reads
`timescale 1ns/1ps
`default_nettype none
module rx_deserializer (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       soft_reset,
    input  wire logic       enable,
    input  wire logic       byte_mode,
    input  wire logic       bit_tick,
    input  wire logic       rx_bit,
    output logic            deliver,
    output logic [7:0]      deliver_data
);

    logic [7:0] shifter;
    logic [7:0] next_shifter;
    logic [2:0] count;
    logic [2:0] next_count;
    logic       next_deliver;
    logic [7:0] next_deliver_data;

    always_comb begin
        next_shifter      = shifter;
        next_count        = count;
        next_deliver      = 1'b0;
        next_deliver_data = deliver_data;
        if (!enable) begin
            next_count = 3'h0;
        end else if (bit_tick) begin
            next_shifter = {shifter[6:0], rx_bit};
            if (byte_mode) begin
                next_count = count + 3'h1;
                if (count == 3'h7) begin
                    next_deliver      = 1'b1;
                    next_deliver_data = {shifter[6:0], rx_bit};
                end
            end else begin
                next_deliver      = 1'b1;
                next_deliver_data = {7'h00, shifter[0]};
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shifter      <= 8'h00;
            count        <= 3'h0;
            deliver      <= 1'b0;
            deliver_data <= 8'h00;
        end else if (soft_reset) begin
            shifter      <= 8'h00;
            count        <= 3'h0;
            deliver      <= 1'b0;
            deliver_data <= 8'h00;
        end else begin
            shifter      <= next_shifter;
            count        <= next_count;
            deliver      <= next_deliver;
            deliver_data <= next_deliver_data;
        end
    end

endmodule : rx_deserializer
`default_nettype wire

/* File: rtl/rf_data_buffer_and_slicer_lock.sv */
// Purpose: RF data buffer, serializers and slicer lock
// Assumes: baud_tick is one clock wide; Manchester ticks every chip
// Notes:   Transmit bit period is two ticks in Manchester mode
//
// The implementer's own choices: the strobed register port and the register addresses.
`include "rf_buffer_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rf_data_buffer_and_slicer_lock
    import rf_buffer_pkg::*;
#(
    parameter int FILTER_WIDTH = 8
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [7:0]              address,
    input  wire logic [7:0]              write_data,
    input  wire logic                    write_strobe,
    input  wire logic                    read_strobe,
    output logic      [7:0]              read_data,
    input  wire logic                    baud_tick,
    input  wire logic                    rx_bit,
    input  wire logic                    sample_valid,
    input  wire logic [FILTER_WIDTH-1:0] data_filter,
    output logic                         tx_bit,
    output logic                         sliced_bit,
    output logic                         rf_irq_flag
);

    logic [7:0] rf_data_buffer;
    logic [7:0] rf_control;
    logic [7:0] rf_main_control;
    logic [7:0] demod_control_one;
    logic [7:0] demod_control_two;
    logic [7:0] next_rf_data_buffer;
    logic [7:0] next_rf_control;
    logic [7:0] next_rf_main_control;
    logic [7:0] next_demod_control_one;
    logic [7:0] next_demod_control_two;
    logic [7:0] next_read_data;
    logic       next_rf_irq_flag;

    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic [3:0] tx_left;
    logic [3:0] next_tx_left;
    logic       tx_half;
    logic       next_tx_half;
    logic       next_tx_bit;
    logic       tx_was_on;
    logic       next_tx_was_on;

    logic       byte_mode;
    logic       manchester;
    logic       tx_on;
    logic       rx_on;
    logic       soft_reset;
    logic       bit_tick;
    logic       rx_half;
    logic       next_rx_half;
    logic       rx_deliver;
    logic [7:0] rx_deliver_data;
    logic       avg_locked;
    logic       tx_load;
    logic [7:0] tx_load_value;

    assign byte_mode  = rf_control[`RF_CONTROL_BYTEMODE_BIT];
    assign manchester = rf_main_control[`MAIN_MANCHESTER_BIT];
    assign tx_on      = !rf_main_control[`MAIN_TRANSMIT_POWER_DOWN_BIT];
    assign rx_on      = !rf_main_control[`MAIN_RECEIVE_POWER_DOWN_BIT] && !tx_on;
    assign soft_reset = !demod_control_one[`MOD1_MODEM_RUN_BIT];
    // Manchester bit period spans two ticks
    assign bit_tick   = baud_tick && (!manchester || rx_half);

    rx_deserializer u_rx (
        .clock        (clock),
        .rst          (rst),
        .soft_reset   (soft_reset),
        .enable       (rx_on),
        .byte_mode    (byte_mode),
        .bit_tick     (bit_tick),
        .rx_bit       (rx_bit),
        .deliver      (rx_deliver),
        .deliver_data (rx_deliver_data)
    );

    slicer_lock #(
        .WIDTH (FILTER_WIDTH)
    ) u_lock (
        .clock        (clock),
        .rst          (rst),
        .soft_reset   (soft_reset),
        .baud_tick    (baud_tick),
        .sample_valid (sample_valid),
        .data_filter  (data_filter),
        .receive_on   (rx_on),
        .lock_select  (demod_control_one[`MOD1_LOCK_SELECT_BIT]),
        .lock_request (demod_control_one[`MOD1_LOCK_REQUEST_BIT]),
        .settling     (demod_control_one[`MOD1_SETTLE_LSB +: 2]),
        .sliced_bit   (sliced_bit),
        .locked       (avg_locked)
    );

    always_comb begin
        next_tx_shift  = tx_shift;
        next_tx_left   = tx_left;
        next_tx_half   = tx_half;
        next_tx_bit    = tx_bit;
        next_tx_was_on = tx_on;
        tx_load        = 1'b0;
        tx_load_value  = byte_mode ? rf_data_buffer
                                   : {7'h00, rf_data_buffer[0]};
        if (!tx_on) begin
            next_tx_left = 4'h0;
            next_tx_half = 1'b0;
        end else if (!tx_was_on) begin
            // Preloaded buffer enters the shifter at once
            tx_load       = 1'b1;
            next_tx_shift = tx_load_value;
            next_tx_left  = byte_mode ? 4'h8 : 4'h1;
        end else if (baud_tick) begin
            next_tx_half = manchester ? !tx_half : 1'b0;
            if (!manchester || tx_half) begin
                if (tx_left != 4'h0) begin
                    next_tx_bit = byte_mode ? tx_shift[7]
                                            : tx_shift[0];
                    next_tx_shift = {tx_shift[6:0], 1'b0};
                    next_tx_left  = tx_left - 4'h1;
                end
                if (tx_left <= 4'h1) begin
                    // Buffer is left as is, so an unwritten byte repeats
                    tx_load       = 1'b1;
                    next_tx_shift = tx_load_value;
                    next_tx_left  = byte_mode ? 4'h8 : 4'h1;
                end
            end
        end
    end

    always_comb begin
        next_rf_data_buffer    = rf_data_buffer;
        next_rf_control        = rf_control;
        next_rf_main_control   = rf_main_control;
        next_demod_control_one = demod_control_one;
        next_demod_control_two = demod_control_two;
        next_rf_irq_flag       = rf_irq_flag;
        next_read_data         = 8'h00;
        next_rx_half           = rx_half;
        if (!manchester || !rx_on)
            next_rx_half = 1'b0;
        else if (baud_tick)
            next_rx_half = !rx_half;
        if (read_strobe) begin
            unique case (address)
                `ADDR_RF_DATA_BUFFER:    next_read_data = rf_data_buffer;
                `ADDR_RF_CONTROL:        next_read_data = rf_control;
                `ADDR_RF_MAIN_CONTROL:   next_read_data = rf_main_control;
                `ADDR_DEMOD_CONTROL_ONE: begin
                    next_read_data = demod_control_one;
                    next_read_data[`MOD1_LOCK_STATE_BIT] = avg_locked;
                end
                `ADDR_DEMOD_CONTROL_TWO: next_read_data = demod_control_two;
                `ADDR_RF_STATUS:
                    next_read_data = {7'h00, rf_irq_flag};
                default:                 next_read_data = 8'h00;
            endcase
        end
        if (write_strobe) begin
            unique case (address)
                `ADDR_RF_DATA_BUFFER:    next_rf_data_buffer = write_data;
                `ADDR_RF_CONTROL:
                    next_rf_control = {4'h0, write_data[3:0]};
                `ADDR_RF_MAIN_CONTROL:
                    next_rf_main_control = {5'h00, write_data[2:0]};
                `ADDR_DEMOD_CONTROL_ONE:
                    next_demod_control_one = {1'b0, write_data[6:5], 1'b0,
                                              write_data[3:0]};
                `ADDR_DEMOD_CONTROL_TWO:
                    next_demod_control_two = {1'b0, write_data[6:0]};
                `ADDR_RF_STATUS:
                    if (write_data[`STATUS_IRQ_BIT])
                        next_rf_irq_flag = 1'b0;
                default: ;
            endcase
        end
        if (rx_deliver)
            next_rf_data_buffer = rx_deliver_data;
        // Hardware set wins over a same-cycle software clear
        if (tx_load || rx_deliver)
            next_rf_irq_flag = 1'b1;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rf_data_buffer    <= 8'h00;
            rf_control        <= `RESET_RF_CONTROL;
            rf_main_control   <= `RESET_RF_MAIN_CONTROL;
            demod_control_one <= `RESET_DEMOD_ONE;
            demod_control_two <= `RESET_DEMOD_TWO;
            rf_irq_flag       <= 1'b0;
            read_data         <= 8'h00;
            rx_half           <= 1'b0;
            tx_shift          <= 8'h00;
            tx_left           <= 4'h0;
            tx_half           <= 1'b0;
            tx_bit            <= 1'b0;
            tx_was_on         <= 1'b0;
        end else begin
            rf_data_buffer    <= next_rf_data_buffer;
            rf_control        <= next_rf_control;
            rf_main_control   <= next_rf_main_control;
            demod_control_one <= next_demod_control_one;
            demod_control_two <= next_demod_control_two;
            rf_irq_flag       <= next_rf_irq_flag;
            read_data         <= next_read_data;
            rx_half           <= next_rx_half;
            tx_shift          <= next_tx_shift;
            tx_left           <= next_tx_left;
            tx_half           <= next_tx_half;
            tx_bit            <= next_tx_bit;
            tx_was_on         <= next_tx_was_on;
        end
    end

endmodule : rf_data_buffer_and_slicer_lock
`default_nettype wire

/* File: testbench/rf_buffer_checker.sv */
// Purpose: Port-level assertions for the RF data buffer block
// Assumes: One clock domain; rst asynchronous, active high
// Notes:   Bound into the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rf_buffer_checker #(
    parameter int FILTER_WIDTH = 8
) (
    input wire logic                    clock,
    input wire logic                    rst,
    input wire logic [7:0]              address,
    input wire logic [7:0]              write_data,
    input wire logic                    write_strobe,
    input wire logic                    read_strobe,
    input wire logic [7:0]              read_data,
    input wire logic                    baud_tick,
    input wire logic                    sample_valid,
    input wire logic [FILTER_WIDTH-1:0] data_filter,
    input wire logic                    tx_bit,
    input wire logic                    sliced_bit,
    input wire logic                    rf_irq_flag
);
    logic [3:0] tick_h;
    logic [3:0] wr_h;
    logic [2:0] samp_h;

    // Effects lag their cause by up to four cycles
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_h <= 4'h0;
            wr_h   <= 4'h0;
            samp_h <= 3'h0;
        end else begin
            tick_h <= {tick_h[2:0], baud_tick};
            wr_h   <= {wr_h[2:0], write_strobe};
            samp_h <= {samp_h[1:0], sample_valid};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_read_idle: assert property (
        !$past(read_strobe) |-> read_data == 8'h00)
        else $error("stray read data");
    a_reserved_zero: assert property (
        $past(read_strobe) && $past(address) == 8'h0c |-> !read_data[7])
        else $error("reserved bit set");
    a_status_mirror: assert property (
        $past(read_strobe) && $past(address) == 8'h14
        |-> read_data[0] == $past(rf_irq_flag))
        else $error("status bit wrong");
    a_irq_cause: assert property (
        $rose(rf_irq_flag) |-> (|tick_h) || (|wr_h))
        else $error("flag rose unprompted");
    a_irq_sticky: assert property (
        $fell(rf_irq_flag) |-> $past(write_strobe)
        && $past(address) == 8'h14 && $past(write_data[0]))
        else $error("flag fell uncleared");
    a_tx_on_tick: assert property (
        $changed(tx_bit) |-> (|tick_h) || (|wr_h))
        else $error("tx bit off tick");
    a_slice_floor: assert property (
        sample_valid && data_filter == '0 |-> ##2 !sliced_bit)
        else $error("sliced bit high at floor");
    a_slice_on_sample: assert property (
        $changed(sliced_bit) |-> (|samp_h) || (|wr_h))
        else $error("sliced bit off sample");

    c_irq: cover property ($rose(rf_irq_flag));
    c_floor: cover property (sample_valid && data_filter == '0);
    c_locked: cover property ($past(read_strobe) && read_data[4]);
endmodule : rf_buffer_checker

bind rf_data_buffer_and_slicer_lock rf_buffer_checker #(
    .FILTER_WIDTH(FILTER_WIDTH)
) checker_i (
    .clock(clock), .rst(rst), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .baud_tick(baud_tick),
    .sample_valid(sample_valid), .data_filter(data_filter),
    .tx_bit(tx_bit), .sliced_bit(sliced_bit), .rf_irq_flag(rf_irq_flag)
);
`default_nettype wire

/* File: testbench/modem_partner.sv */
// Purpose: Modulator and demodulator stand-in for the buffer block
// Assumes: Ticks come only while run is high
// Notes:   Transmit bit captured two cycles after each tick
`timescale 1ns/1ps
`default_nettype none
module modem_partner #(
    parameter int GAP = 4
) (
    input  wire logic       clock,
    input  wire logic       run,
    input  wire logic       tx_bit,
    output logic            baud_tick = 1'b0,
    output logic            rx_bit,
    output logic            sample_valid = 1'b0,
    output logic [7:0]      data_filter = 8'h00
);
    int          phase = 0;
    int          ticks = 0;
    logic [15:0] rx_pat = 16'h0000;
    logic [1:0]  tick_dly = 2'b00;
    logic        tx_q[$];

    assign rx_bit = rx_pat[15];

    always @(posedge clock) begin
        tick_dly     <= {tick_dly[0], baud_tick};
        baud_tick    <= run && phase == GAP - 1;
        sample_valid <= baud_tick;
        if (run) begin
            phase <= (phase == GAP - 1) ? 0 : phase + 1;
        end
        if (baud_tick) begin
            ticks       <= ticks + 1;
            // Inverted refill keeps the line toggling
            rx_pat      <= {rx_pat[14:0], ~rx_pat[15]};
            data_filter <= ticks[0] ? 8'hff : 8'h00;
        end
        if (tick_dly[1]) begin
            tx_q.push_back(tx_bit);
        end
    end
endmodule : modem_partner
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the RF data buffer block
// Assumes: Partner ticks every four clocks while run is high
// Notes:   Bus tasks leave one idle cycle after each strobe
`include "rf_buffer_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic [7:0] write_data = 8'h00;
    logic       write_strobe = 1'b0;
    logic       read_strobe = 1'b0;
    logic       run = 1'b0;
    logic [7:0] read_data;
    logic       baud_tick;
    logic       rx_bit;
    logic       sample_valid;
    logic [7:0] data_filter;
    logic       tx_bit;
    logic       sliced_bit;
    logic       rf_irq_flag;
    int         err_total = 0;
    int         check_count = 0;

    always #2.5 clock = ~clock;

    rf_data_buffer_and_slicer_lock rf_data_buffer_and_slicer_lock_i (
        .clock(clock), .rst(rst), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data),
        .baud_tick(baud_tick), .rx_bit(rx_bit), .sample_valid(sample_valid),
        .data_filter(data_filter), .tx_bit(tx_bit), .sliced_bit(sliced_bit),
        .rf_irq_flag(rf_irq_flag)
    );

    modem_partner modem_partner_i (
        .clock(clock), .run(run), .tx_bit(tx_bit), .baud_tick(baud_tick),
        .rx_bit(rx_bit), .sample_valid(sample_valid),
        .data_filter(data_filter)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        address      <= a;
        write_data   <= v;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        address     <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 check(read_data, exp);
        @(posedge clock);
    endtask : rd_check

    task automatic run_ticks(input int n);
        int target;
        target = modem_partner_i.ticks + n;
        run <= 1'b1;
        while (modem_partner_i.ticks < target) @(posedge clock);
        run <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : run_ticks

    function automatic logic qbit(input int i);
        return modem_partner_i.tx_q[i];
    endfunction : qbit

    function automatic logic [7:0] cap(input int base);
        for (int i = 0; i < 8; i++) cap[7-i] = qbit(base + i);
    endfunction : cap

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic test_reset;
        rd_check(`ADDR_RF_DATA_BUFFER, 8'h00);
        rd_check(`ADDR_RF_CONTROL, `RESET_RF_CONTROL);
        rd_check(`ADDR_RF_MAIN_CONTROL, `RESET_RF_MAIN_CONTROL);
        rd_check(`ADDR_DEMOD_CONTROL_ONE, `RESET_DEMOD_ONE);
        rd_check(`ADDR_DEMOD_CONTROL_TWO, `RESET_DEMOD_TWO);
        rd_check(`ADDR_RF_STATUS, 8'h00);
        rd_check(8'h20, 8'h00);
        done("reset");
    endtask : test_reset

    task automatic test_tx_byte;
        wr(`ADDR_RF_CONTROL, 8'h07);
        wr(`ADDR_DEMOD_CONTROL_ONE, 8'h2d);
        wr(`ADDR_RF_DATA_BUFFER, 8'ha5);
        wr(`ADDR_RF_STATUS, 8'h01);
        wr(`ADDR_RF_MAIN_CONTROL, 8'h02);
        repeat (2) @(posedge clock);
        rd_check(`ADDR_RF_STATUS, 8'h01);
        wr(`ADDR_RF_STATUS, 8'h01);
        modem_partner_i.tx_q.delete();
        run_ticks(16);
        check(cap(0), 8'ha5);
        check(cap(8), 8'ha5);
        rd_check(`ADDR_RF_STATUS, 8'h01);
        rd_check(`ADDR_RF_DATA_BUFFER, 8'ha5);
        wr(`ADDR_RF_MAIN_CONTROL, 8'h03);
        done("tx_byte");
    endtask : test_tx_byte

    task automatic test_tx_bit;
        wr(`ADDR_RF_CONTROL, 8'h06);
        wr(`ADDR_RF_DATA_BUFFER, 8'hfe);
        wr(`ADDR_RF_MAIN_CONTROL, 8'h06);
        modem_partner_i.tx_q.delete();
        run_ticks(4);
        check({6'h00, qbit(1), qbit(2)}, 8'h00);
        wr(`ADDR_RF_STATUS, 8'h01);
        wr(`ADDR_RF_DATA_BUFFER, 8'h01);
        modem_partner_i.tx_q.delete();
        run_ticks(4);
        // Manchester: the new bit shows only on the fourth tick, the second bit period
        check({6'h00, qbit(2), qbit(3)}, 8'h01);
        rd_check(`ADDR_RF_STATUS, 8'h01);
        wr(`ADDR_RF_MAIN_CONTROL, 8'h03);
        done("tx_bit");
    endtask : test_tx_bit

    task automatic test_rx;
        wr(`ADDR_RF_CONTROL, 8'h07);
        wr(`ADDR_RF_STATUS, 8'h01);
        modem_partner_i.rx_pat = 16'h3cc3;
        wr(`ADDR_RF_MAIN_CONTROL, 8'h01);
        run_ticks(8);
        rd_check(`ADDR_RF_DATA_BUFFER, 8'h3c);
        rd_check(`ADDR_RF_STATUS, 8'h01);
        run_ticks(8);
        rd_check(`ADDR_RF_DATA_BUFFER, 8'hc3);
        wr(`ADDR_RF_MAIN_CONTROL, 8'h03);
        wr(`ADDR_RF_CONTROL, 8'h06);
        modem_partner_i.rx_pat = 16'h8000;
        wr(`ADDR_RF_MAIN_CONTROL, 8'h01);
        run_ticks(2);
        rd_check(`ADDR_RF_DATA_BUFFER, 8'h01);
        run_ticks(1);
        rd_check(`ADDR_RF_DATA_BUFFER, 8'h00);
        done("rx");
    endtask : test_rx

    task automatic test_lock;
        int n[4] = '{11, 22, 43, 86};
        wr(`ADDR_RF_MAIN_CONTROL, 8'h03);
        wr(`ADDR_DEMOD_CONTROL_ONE, 8'h6d);
        rd_check(`ADDR_DEMOD_CONTROL_ONE, 8'h7d);
        wr(`ADDR_DEMOD_CONTROL_ONE, 8'h2d);
        rd_check(`ADDR_DEMOD_CONTROL_ONE, 8'h2d);
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_RF_MAIN_CONTROL, 8'h03);
            wr(`ADDR_DEMOD_CONTROL_ONE, 8'h00);
            // Auto mode must ignore the request bit
            wr(`ADDR_DEMOD_CONTROL_ONE, {4'h4, 2'(c), 2'b01});
            wr(`ADDR_RF_MAIN_CONTROL, 8'h01);
            run_ticks(n[c] - 1);
            rd_check(`ADDR_DEMOD_CONTROL_ONE, {4'h4, 2'(c), 2'b01});
            run_ticks(1);
            rd_check(`ADDR_DEMOD_CONTROL_ONE, {4'h5, 2'(c), 2'b01});
        end
        wr(`ADDR_RF_MAIN_CONTROL, 8'h03);
        rd_check(`ADDR_DEMOD_CONTROL_ONE, 8'h5d);
        wr(`ADDR_DEMOD_CONTROL_ONE, 8'h00);
        rd_check(`ADDR_DEMOD_CONTROL_ONE, 8'h00);
        done("lock");
    endtask : test_lock

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        test_reset();
        test_tx_byte();
        test_tx_bit();
        test_rx();
        test_lock();
        tally_and_finish();
    end

    // Whole run needs about 1000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
